// ### rps_defs.svh
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH

// timer width, wide enough for the lock phase
`define RPS_TMR_W            18
// recognition of an external reset, in oscillator cycles
`define RPS_RST_LOW_OSC      8
`define RPS_RST_LOW_CYC      4'(`RPS_RST_LOW_OSC * `RPS_OSC_PER_CLK)
// watchdog-driven reset pulse length
`define RPS_WDOG_PULSE_OSC   512
`define RPS_WDOG_PULSE_CYC   18'(`RPS_WDOG_PULSE_OSC * `RPS_OSC_PER_CLK)
// bus activity becomes valid this long after release
`define RPS_BUS_VALID_OSC    32
`define RPS_BUS_VALID_CYC    18'(`RPS_BUS_VALID_OSC * `RPS_OSC_PER_CLK)
// boot-mode pins are held this long after release
`define RPS_BOOT_HOLD_OSC    200
`define RPS_BOOT_HOLD_CYC    18'(`RPS_BOOT_HOLD_OSC * `RPS_OSC_PER_CLK)
// the core clock is the oscillator clock
`define RPS_OSC_PER_CLK      1
// lock phase length, default for the top parameter
`define RPS_PLL_LOCK_OSC     131072
// multiplier control value after reset (bypass)
`define RPS_PLL_CTRL_RST     16'h0000
// limp-mode system clock target and resulting divider
`define RPS_CORE_KHZ         100000
`define RPS_LIMP_KHZ         2500
`define RPS_LIMP_DIV         8'(`RPS_CORE_KHZ / `RPS_LIMP_KHZ)
`define RPS_BOOT_W           4

`endif

// ### rps_pkg.sv
package rps_pkg;
	// reset sequence states
	typedef enum logic [2:0] {
		SEQ_HELD,
		SEQ_WDOG,
		SEQ_WAIT_BUS,
		SEQ_WAIT_BOOT,
		SEQ_RUN
	} rps_seq_e;

	typedef logic [15:0] rps_ctrl_t;
endpackage

// ### rps_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "rps_defs.svh"

// ****************************************
// one-shot timer handshake
// ****************************************
interface rps_tmr_if;
	logic                   start;
	logic [`RPS_TMR_W-1:0]  loadVal;
	logic                   busy;
	logic                   done;

	modport owner (output start, output loadVal, input busy, input done);
	modport timer (input start, input loadVal, output busy, output done);
endinterface : rps_tmr_if

`default_nettype wire

// ### rps_cycle_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "rps_defs.svh"

// ****************************************
// one-shot down counter
// ****************************************
module rps_cycle_timer (
	// clock and reset
	input  wire logic    core_clk,
	input  wire logic    nrst,
	// handshake
	rps_tmr_if.timer     tmr
);
	import rps_pkg::*;

	logic [`RPS_TMR_W-1:0] cnt_reg;
	logic                  busy_reg;
	// done marks the last counted cycle, so a load of N spans exactly N cycles
	wire                   lastCycle = busy_reg && (cnt_reg == '0);

	// a new start restarts the count even while running
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
		end else begin
			if (tmr.start) begin
				cnt_reg  <= tmr.loadVal - `RPS_TMR_W'(1);
				busy_reg <= 1'b1;
			end else if (lastCycle) begin
				busy_reg <= 1'b0;
			end else if (busy_reg) begin
				cnt_reg  <= cnt_reg - `RPS_TMR_W'(1);
			end
		end
	end

	assign tmr.busy = busy_reg;
	assign tmr.done = lastCycle;
endmodule // rps_cycle_timer

`default_nettype wire

// ### rps_reset_pll_seq.sv
// How it works
// - watchdog drives a 512-cycle reset pulse
// - bus activity valid 32 cycles after release
// - boot pins sampled after reset, select boot
// - multiplier write starts 131072-cycle lock phase
// - system clock halved during lock outside limp mode
// - system clock equals oscillator times value/2
// - new frequency applied when lock completes
// - limp mode runs system clock at 1-5 MHz
`timescale 1ns/10ps
`default_nettype none
`include "rps_defs.svh"

module rps_reset_pll_seq #(
	parameter int unsigned PLL_LOCK_CYCLES = `RPS_PLL_LOCK_OSC * `RPS_OSC_PER_CLK
) (
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    nrst,
	// external reset pin, open drain
	input  wire logic                    extRstPinIn,
	output logic                         extRstPinOut,
	output logic                         extRstPinOeN,
	// watchdog event
	input  wire logic                    wdogFire,
	// boot-mode strapping
	input  wire logic [`RPS_BOOT_W-1:0]  bootModePins,
	output logic      [`RPS_BOOT_W-1:0]  bootMode,
	output logic                         bootValid,
	// core reset and bus activity
	output logic                         coreRstN,
	output logic                         busValid,
	// multiplier control write
	input  wire logic                    pllCtrlWrEn,
	input  wire rps_pkg::rps_ctrl_t      pllCtrlWrData,
	// system clock control
	input  wire logic                    limpMode,
	output logic                         sysClkEn,
	output logic                         pllLocking,
	output logic      [14:0]             sysClkMult
);
	import rps_pkg::*;

	// ****************************************
	// state and timers
	// ****************************************
	// sequencer state and pin filter
	rps_seq_e                 seq_reg;
	rps_seq_e                 seq_next;
	logic [3:0]               lowCnt_reg;
	// registered outputs of the reset side
	logic [`RPS_BOOT_W-1:0]   bootMode_reg;
	logic                     bootValid_reg;
	logic                     busValid_reg;
	logic                     coreRstN_reg;
	logic                     drive_reg;
	// multiplier and system clock enable
	rps_ctrl_t                pendCtrl_reg;
	rps_ctrl_t                actCtrl_reg;
	logic                     locking_reg;
	logic                     halfPh_reg;
	logic [7:0]               limpCnt_reg;
	logic                     sysClkEn_reg;

	// one timer walks the reset sequence, the other times the lock phase
	rps_tmr_if seqTmr ();
	rps_tmr_if lockTmr ();

	rps_cycle_timer seqTimer (
		.core_clk (core_clk),
		.nrst     (nrst),
		.tmr      (seqTmr)
	);

	rps_cycle_timer lockTimer (
		.core_clk (core_clk),
		.nrst     (nrst),
		.tmr      (lockTmr)
	);

	// ****************************************
	// reset recognition and sequencing
	// ****************************************

	// a glitch shorter than the minimum low time is ignored
	wire pinLow      = !extRstPinIn;
	wire rstSeen     = pinLow && (lowCnt_reg == (`RPS_RST_LOW_CYC - 4'(1)));
	// no new pulse while one is driven or a reset is already held
	wire wdogStart   = wdogFire && (seq_reg != SEQ_WDOG) && (seq_reg != SEQ_HELD);
	// wait for our own drive to end, else the pin reads back low
	wire heldRelease = (seq_reg == SEQ_HELD) && !pinLow && !drive_reg;
	// the strap sample falls on the last cycle of the hold window
	wire bootCapture = (seq_reg == SEQ_WAIT_BOOT) && seqTmr.done;
	// core held while a reset is recognised or driven
	wire inReset     = (seq_next == SEQ_HELD) || (seq_next == SEQ_WDOG);

	// next sequence state
	always_comb begin
		seq_next = seq_reg;
		case (seq_reg)
			SEQ_HELD:      if (heldRelease) seq_next = SEQ_WAIT_BUS;
			SEQ_WDOG:      if (seqTmr.done) seq_next = SEQ_HELD;
			SEQ_WAIT_BUS:  if (seqTmr.done) seq_next = SEQ_WAIT_BOOT;
			SEQ_WAIT_BOOT: if (seqTmr.done) seq_next = SEQ_RUN;
			SEQ_RUN:       seq_next = SEQ_RUN;
			default:       seq_next = SEQ_HELD;
		endcase
		// a watchdog outranks the pin; its own pulse never re-triggers the filter
		if (wdogStart)
			seq_next = SEQ_WDOG;
		else if (rstSeen && seq_reg != SEQ_WDOG)
			seq_next = SEQ_HELD;
	end

	// timer loads: release delay, then the remainder up to boot sampling
	// each load is the exact number of cycles up to the cycle that acts on done
	assign seqTmr.start   = wdogStart || heldRelease
		|| (seq_reg == SEQ_WAIT_BUS && seqTmr.done);
	assign seqTmr.loadVal = wdogStart ? `RPS_WDOG_PULSE_CYC :
		heldRelease ? `RPS_BUS_VALID_CYC :
		(`RPS_BOOT_HOLD_CYC - `RPS_BUS_VALID_CYC);

	// consecutive low cycles on the pin
	// saturates, so a long low is recognised once and then simply held
	always_ff @(posedge core_clk) begin
		if (!nrst)
			lowCnt_reg <= 4'h0;
		else if (!pinLow)
			lowCnt_reg <= 4'h0;
		else if (lowCnt_reg != (`RPS_RST_LOW_CYC - 4'(1)))
			lowCnt_reg <= lowCnt_reg + 4'h1;
	end

	// sequence registers
	// outputs follow the next state, so they move together with the state
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			seq_reg       <= SEQ_HELD;
			drive_reg     <= 1'b0;
			coreRstN_reg  <= 1'b0;
			busValid_reg  <= 1'b0;
			bootValid_reg <= 1'b0;
			bootMode_reg  <= '0;
		end else begin
			seq_reg      <= seq_next;
			drive_reg    <= (seq_next == SEQ_WDOG);
			coreRstN_reg <= !inReset;
			busValid_reg <= (seq_next == SEQ_WAIT_BOOT) || (seq_next == SEQ_RUN);
			if (inReset)
				bootValid_reg <= 1'b0;
			else if (bootCapture) begin
				bootMode_reg  <= bootModePins;
				bootValid_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// multiplier and lock phase
	// ****************************************

	// a write during lock restarts the whole lock phase
	// writes while the core is held in reset are dropped
	assign lockTmr.start   = pllCtrlWrEn && coreRstN_reg;
	assign lockTmr.loadVal = `RPS_TMR_W'(PLL_LOCK_CYCLES);

	// the old multiplier stays in force until the lock phase ends
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pendCtrl_reg <= `RPS_PLL_CTRL_RST;
			actCtrl_reg  <= `RPS_PLL_CTRL_RST;
			locking_reg  <= 1'b0;
		end else begin
			if (lockTmr.start) begin
				pendCtrl_reg <= pllCtrlWrData;
				locking_reg  <= 1'b1;
			end else if (lockTmr.done) begin
				actCtrl_reg  <= pendCtrl_reg;
				locking_reg  <= 1'b0;
			end
		end
	end

	// ****************************************
	// system clock enable
	// ****************************************

	// limp rate wins, then the half rate of the lock phase, else every cycle
	wire limpTick   = (limpCnt_reg == (`RPS_LIMP_DIV - 8'(1)));
	// the write cycle already counts as lock, so halving starts at once
	wire lockActive = locking_reg || lockTmr.start;
	wire enNext     = limpMode ? limpTick :
		lockActive ? !halfPh_reg : 1'b1;

	// the limp divider restarts whenever limp mode is left
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			halfPh_reg   <= 1'b0;
			limpCnt_reg  <= 8'h00;
			sysClkEn_reg <= 1'b0;
		end else begin
			halfPh_reg   <= lockActive ? !halfPh_reg : 1'b0;
			limpCnt_reg  <= (!limpMode || limpTick) ? 8'h00 : limpCnt_reg + 8'h01;
			sysClkEn_reg <= enNext;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// open-drain data fixed low, only the enable moves
	assign extRstPinOut = 1'b0;
	assign extRstPinOeN = !drive_reg;       // low while pulling the pin
	assign coreRstN     = coreRstN_reg;
	assign busValid     = busValid_reg;
	assign bootMode     = bootMode_reg;
	assign bootValid    = bootValid_reg;
	assign pllLocking   = locking_reg;
	assign sysClkEn     = sysClkEn_reg;
	assign sysClkMult   = actCtrl_reg[15:1];
endmodule // rps_reset_pll_seq

`default_nettype wire

// ### rps_reset_pll_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// sequencer checker
// ****************************************
module rps_reset_pll_seq_asserts #(
	parameter int unsigned PLL_LOCK_CYCLES = 64
) (
	// watched ports
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic extRstPinIn,
	input wire logic extRstPinOut,
	input wire logic extRstPinOeN,
	input wire logic wdogFire,
	input wire logic coreRstN,
	input wire logic busValid,
	input wire logic bootValid,
	input wire logic pllCtrlWrEn,
	input wire logic limpMode,
	input wire logic sysClkEn,
	input wire logic pllLocking
);
	logic [9:0] lowCnt_reg;
	logic [7:0] lockCnt_reg;
	// run lengths of the driven pulse and of the lock phase
	always_ff @(posedge core_clk) begin
		lowCnt_reg  <= (!nrst || extRstPinOeN) ? 10'h000 : lowCnt_reg + 10'h001;
		lockCnt_reg <= (!nrst || !pllLocking) ? 8'h00 : lockCnt_reg + 8'h01;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	pin_filter_a: assert property ((!extRstPinIn && extRstPinOeN)[*8] |=> !coreRstN)
		else $error("long pin low missed");
	wdog_start_a: assert property (wdogFire && coreRstN && extRstPinOeN |=> !extRstPinOeN)
		else $error("watchdog not driven");
	wdog_len_a: assert property ($rose(extRstPinOeN) |-> lowCnt_reg == 10'h200)
		else $error("watchdog pulse length");
	od_drive_a: assert property (!extRstPinOeN |-> !extRstPinOut && !coreRstN)
		else $error("pin drive wrong");
	bus_delay_a: assert property ($rose(coreRstN) |-> ##32 $rose(busValid))
		else $error("bus valid delay");
	boot_delay_a: assert property ($rose(coreRstN) |-> ##200 $rose(bootValid))
		else $error("boot sample delay");
	lock_start_a: assert property (pllCtrlWrEn && coreRstN |=> pllLocking)
		else $error("lock not started");
	lock_len_a: assert property ($fell(pllLocking) |-> lockCnt_reg == 8'(PLL_LOCK_CYCLES))
		else $error("lock length");
	lock_half_a: assert property (pllLocking && $past(pllLocking) && !limpMode
		|-> sysClkEn != $past(sysClkEn)) else $error("lock clock not halved");
	limp_rate_a: assert property (limpMode && $past(limpMode) && sysClkEn
		|=> (!sysClkEn || !$past(limpMode))[*8]) else $error("limp too fast");
endmodule // rps_reset_pll_seq_asserts
bind rps_reset_pll_seq rps_reset_pll_seq_asserts #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_chk (
	.core_clk(core_clk), .nrst(nrst), .extRstPinIn(extRstPinIn),
	.extRstPinOut(extRstPinOut), .extRstPinOeN(extRstPinOeN), .wdogFire(wdogFire),
	.coreRstN(coreRstN), .busValid(busValid), .bootValid(bootValid),
	.pllCtrlWrEn(pllCtrlWrEn), .limpMode(limpMode), .sysClkEn(sysClkEn),
	.pllLocking(pllLocking)
);
`default_nettype wire

// ### rps_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "rps_defs.svh"
// ****************************************
// reset source and strapping
// ****************************************
module rps_pin_model (
	// clock and bench controls
	input  wire logic                   core_clk,
	input  wire logic                   srcRstN,
	input  wire logic [`RPS_BOOT_W-1:0] strapVal,
	// pin and straps
	input  wire logic                   extRstPinOut,
	input  wire logic                   extRstPinOeN,
	output logic                        extRstPinIn,
	output logic      [`RPS_BOOT_W-1:0] bootModePins
);
	logic [7:0] holdCnt_reg;
	// pulled-up wire, low if either party pulls
	assign extRstPinIn = srcRstN & (extRstPinOeN | extRstPinOut);
	// straps flip once the hold is over, so a late sample shows
	assign bootModePins = (holdCnt_reg < 8'hD2) ? strapVal : ~strapVal;
	// cycles since the pin went high
	always_ff @(posedge core_clk) begin
		holdCnt_reg <= !extRstPinIn ? 8'h00 : holdCnt_reg + {7'h00, holdCnt_reg != 8'hFF};
	end
endmodule // rps_pin_model
`default_nettype wire

// ### rps_reset_pll_seq_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "rps_defs.svh"
// ****************************************
// sequencer bench
// ****************************************
module rps_reset_pll_seq_tb_top;
	import rps_pkg::*;
	localparam int unsigned LOCK = 64;
	logic                   core_clk = 1'b0, nrst = 1'b0, srcRstN = 1'b0, wdogFire = 1'b0;
	logic                   pllCtrlWrEn = 1'b0, limpMode = 1'b0;
	rps_ctrl_t              wrData = 16'h0000;
	logic [`RPS_BOOT_W-1:0] strapVal = 4'hA, pins, bootMode;
	logic                   pinIn, pinOut, oeN, bootValid, coreRstN, busValid, sysClkEn, lck;
	logic [14:0]            sysClkMult;
	int                     miscompares = 0, tests_run = 0;
	always #5 core_clk = ~core_clk;
	rps_pin_model u_mdl (.core_clk(core_clk), .srcRstN(srcRstN), .strapVal(strapVal),
		.extRstPinOut(pinOut), .extRstPinOeN(oeN), .extRstPinIn(pinIn), .bootModePins(pins));
	rps_reset_pll_seq #(.PLL_LOCK_CYCLES(LOCK)) u_dut (.core_clk(core_clk), .nrst(nrst),
		.extRstPinIn(pinIn), .extRstPinOut(pinOut), .extRstPinOeN(oeN), .wdogFire(wdogFire),
		.bootModePins(pins), .bootMode(bootMode), .bootValid(bootValid), .coreRstN(coreRstN),
		.busValid(busValid), .pllCtrlWrEn(pllCtrlWrEn), .pllCtrlWrData(wrData),
		.limpMode(limpMode), .sysClkEn(sysClkEn), .pllLocking(lck), .sysClkMult(sysClkMult));
	task automatic chk(input string what, input logic [17:0] got, input logic [17:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// sysClkEn pulses over n cycles
	task automatic count_en(input int n, output logic [17:0] c);
		c = 18'h00000;
		repeat (n) begin
			tick(1);
			c = c + sysClkEn;
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// power-up, straps captured after release
	task automatic t_powerup;
		tick(2);
		nrst = 1'b1;
		tick(8);
		srcRstN = 1'b1;
		tick(32);
		chk("bus early", busValid, 1'b0);
		tick(1);
		chk("bus on", busValid, 1'b1);
		tick(167);
		chk("boot early", bootValid, 1'b0);
		tick(7);
		chk("bootMode", bootMode, strapVal);
		chk("bootValid", bootValid, 1'b1);
		chk("busValid", busValid, 1'b1);
	endtask
	// seven lows ignored, nine recognised
	task automatic t_glitch;
		srcRstN = 1'b0;
		tick(7);
		srcRstN = 1'b1;
		tick(3);
		chk("short low", coreRstN, 1'b1);
		srcRstN = 1'b0;
		tick(9);
		chk("warm reset", coreRstN, 1'b0);
		srcRstN = 1'b1;
		tick(210);
	endtask
	// watchdog pulls the pin for its pulse
	task automatic t_wdog;
		wdogFire = 1'b1;
		tick(1);
		wdogFire = 1'b0;
		tick(1);
		chk("wd start", pinIn, 1'b0);
		tick(510);
		chk("wd mid", pinIn, 1'b0);
		tick(1);
		chk("wd end", pinIn, 1'b1);
		tick(212);
	endtask
	// both documented multiplier values
	task automatic t_pll;
		logic [17:0] c;
		for (int i = 1; i <= 2; i++) begin
			wrData = rps_ctrl_t'(4 * i);
			pllCtrlWrEn = 1'b1;
			tick(1);
			pllCtrlWrEn = 1'b0;
			tick(1);
			chk("locking", lck, 1'b1);
			count_en(32, c);
			chk("half rate", c, 18'h10);
			chk("mult held", sysClkMult, 15'(2 * i - 2));
			tick(LOCK);
			chk("lock done", lck, 1'b0);
			chk("mult", sysClkMult, 15'(2 * i));
			chk("full rate", sysClkEn, 1'b1);
		end
	endtask
	// write while held in reset is dropped
	task automatic t_refuse;
		srcRstN = 1'b0;
		tick(9);
		pllCtrlWrEn = 1'b1;
		tick(1);
		pllCtrlWrEn = 1'b0;
		tick(2);
		chk("held write", lck, 1'b0);
		srcRstN = 1'b1;
		tick(210);
	endtask
	// limp rate, ten pulses in 400 cycles is 2.5 MHz
	task automatic t_limp;
		logic [17:0] c;
		limpMode = 1'b1;
		tick(5);
		count_en(400, c);
		chk("limp rate", c, 18'h0A);
		limpMode = 1'b0;
	endtask
	initial begin
		t_powerup();
		t_glitch();
		t_wdog();
		t_pll();
		t_refuse();
		t_limp();
		tally_and_finish();
	end
	// hang guard, about two and a half times the expected run
	initial begin
		tick(5000);
		miscompares++;
		tally_and_finish();
	end
endmodule // rps_reset_pll_seq_tb_top
`default_nettype wire
